// file: common/ptc_pkg.sv
package ptc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] AUX_UPPER_ADDR = 12'h18C;
  localparam logic [11:0] AUX_LOWER_ADDR = 12'h190;
  localparam logic [11:0] CAPTURE_CFG_ADDR = 12'h194;
  localparam logic [11:0] PORT2_STATUS_ADDR = 12'h198;

  // ----------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------
  localparam int unsigned P2_MASTER_BIT = 31;
  localparam int unsigned P2_PRI_BIT = 30;
  localparam int unsigned P2_ALT1_BIT = 29;
  localparam int unsigned P2_ALT2_BIT = 28;
  localparam int unsigned P2_ALT3_BIT = 27;
  localparam int unsigned P2_USER_BIT = 26;
  localparam int unsigned P2_LOCK_RX_BIT = 25;
  localparam int unsigned P2_LOCK_TX_BIT = 24;
  localparam int unsigned P1_MASTER_BIT = 23;
  localparam int unsigned CFG_LSB = 23;
  localparam int unsigned CFG_W = 9;
  localparam int unsigned AUX_UPPER_W = 16;

  // reset value of bits 31:23
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h086;

  // ----------------------------------------------------------------
  // well-known destination addresses
  // ----------------------------------------------------------------
  localparam logic [47:0] PTP_PRI_ADDR = 48'h01005E000181;
  localparam logic [47:0] PTP_ALT1_ADDR = 48'h01005E000182;
  localparam logic [47:0] PTP_ALT2_ADDR = 48'h01005E000183;
  localparam logic [47:0] PTP_ALT3_ADDR = 48'h01005E000184;

  // ----------------------------------------------------------------
  // frame message types
  // ----------------------------------------------------------------
  localparam logic [3:0] MSG_SYNC = 4'h0;
  localparam logic [3:0] MSG_DELAY_REQ = 4'h1;

  localparam int unsigned TS_W = 64;
  localparam int unsigned UID_W = 48;
  localparam int unsigned SEQ_W = 16;
endpackage : ptc_pkg

// file: rtl/ptc_capture_cfg.sv
`timescale 1ns/1ns
// Overview of operation
// - port 2 role set: capture on sent Sync and received Delay_Req
// - port 2 role clear (reset): capture on sent Delay_Req, received Sync
// - primary enable (reset one) admits 01:00:5E:00:01:81 on port 2
// - first alternate enable (reset zero) admits 01:00:5E:00:01:82 on port 2
// - second alternate enable (reset zero) admits 01:00:5E:00:01:83 on port 2
// - third alternate enable (reset zero) admits 01:00:5E:00:01:84 on port 2
// - user enable admits the programmable auxiliary address on port 2
// - receive lock (reset one) keeps stored values while receive flag set
// - transmit lock (reset one) keeps stored values while transmit flag set
// - port 1 role bit selects master or slave capture frames, resets zero
// - auxiliary address is 16-bit upper plus 32-bit lower register
module ptc_capture_cfg
  import ptc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port 2 frame events, one-cycle strobes at the timestamp point
  input wire logic p2_tx_frame,
  input wire logic p2_rx_frame,
  input wire logic [47:0] p2_dest_addr,
  input wire logic [3:0] p2_msg_type,
  input wire logic [UID_W-1:0] p2_src_uid,
  input wire logic [SEQ_W-1:0] p2_seq_id,
  input wire logic [TS_W-1:0] clock_now,
  // port 1 qualification, address match done by port 1 path
  input wire logic p1_tx_frame,
  input wire logic p1_rx_frame,
  input wire logic [3:0] p1_msg_type,
  // port 2 captured values and flags
  output logic [TS_W-1:0] p2_rx_clock,
  output logic [UID_W-1:0] p2_rx_uid,
  output logic [SEQ_W-1:0] p2_rx_seq,
  output logic [TS_W-1:0] p2_tx_clock,
  output logic [UID_W-1:0] p2_tx_uid,
  output logic [SEQ_W-1:0] p2_tx_seq,
  output logic p2_rx_flag,
  output logic p2_tx_flag,
  // port 1 capture requests towards the port 1 capture logic
  output logic p1_tx_capture,
  output logic p1_rx_capture,
  output logic p1_master_role
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg_ff;
  logic [AUX_UPPER_W-1:0] aux_upper_ff;
  logic [31:0] aux_lower_ff;
  logic [TS_W-1:0] rx_clock_ff;
  logic [UID_W-1:0] rx_uid_ff;
  logic [SEQ_W-1:0] rx_seq_ff;
  logic [TS_W-1:0] tx_clock_ff;
  logic [UID_W-1:0] tx_uid_ff;
  logic [SEQ_W-1:0] tx_seq_ff;
  logic rx_flag_ff;
  logic tx_flag_ff;
  logic p1_tx_cap_ff;
  logic p1_rx_cap_ff;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire acc = psel && penable && clk_en;
  wire wr_en = acc && pwrite;
  wire hit_upper = (paddr == AUX_UPPER_ADDR);
  wire hit_lower = (paddr == AUX_LOWER_ADDR);
  wire hit_cfg = (paddr == CAPTURE_CFG_ADDR);
  wire hit_stat = (paddr == PORT2_STATUS_ADDR);
  wire hit_any = hit_upper || hit_lower || hit_cfg || hit_stat;
  wire wr_upper = wr_en && hit_upper;
  wire wr_lower = wr_en && hit_lower;
  wire wr_cfg = wr_en && hit_cfg;
  wire [AUX_UPPER_W-1:0] upper_wdata = pwdata[AUX_UPPER_W-1:0];
  // status: write one to bit 0 clears rx flag, bit 1 clears tx flag
  wire clr_rx = wr_en && hit_stat && pwdata[0];
  wire clr_tx = wr_en && hit_stat && pwdata[1];

  // pready waits on clk_en so a frozen block never completes a transfer
  assign pready = clk_en;
  assign pslverr = psel && penable && !hit_any;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  wire p2_master = cfg_ff[P2_MASTER_BIT-CFG_LSB];
  wire p2_pri_en = cfg_ff[P2_PRI_BIT-CFG_LSB];
  wire p2_alt1_en = cfg_ff[P2_ALT1_BIT-CFG_LSB];
  wire p2_alt2_en = cfg_ff[P2_ALT2_BIT-CFG_LSB];
  wire p2_alt3_en = cfg_ff[P2_ALT3_BIT-CFG_LSB];
  wire p2_user_en = cfg_ff[P2_USER_BIT-CFG_LSB];
  wire p2_lock_rx = cfg_ff[P2_LOCK_RX_BIT-CFG_LSB];
  wire p2_lock_tx = cfg_ff[P2_LOCK_TX_BIT-CFG_LSB];
  wire p1_master = cfg_ff[P1_MASTER_BIT-CFG_LSB];
  wire [47:0] aux_addr = {aux_upper_ff, aux_lower_ff};

  // ----------------------------------------------------------------
  // address recognition
  // ----------------------------------------------------------------
  wire m_pri = p2_pri_en && (p2_dest_addr == PTP_PRI_ADDR);
  wire m_alt1 = p2_alt1_en && (p2_dest_addr == PTP_ALT1_ADDR);
  wire m_alt2 = p2_alt2_en && (p2_dest_addr == PTP_ALT2_ADDR);
  wire m_alt3 = p2_alt3_en && (p2_dest_addr == PTP_ALT3_ADDR);
  wire m_user = p2_user_en && (p2_dest_addr == aux_addr);
  wire p2_is_ptp = m_pri || m_alt1 || m_alt2 || m_alt3 || m_user;

  // ----------------------------------------------------------------
  // capture qualification
  // ----------------------------------------------------------------
  // master: sent Sync, received Delay_Req; slave: the reverse
  wire [3:0] p2_tx_type = p2_master ? MSG_SYNC : MSG_DELAY_REQ;
  wire [3:0] p2_rx_type = p2_master ? MSG_DELAY_REQ : MSG_SYNC;
  wire p2_tx_qual = p2_tx_frame && p2_is_ptp && (p2_msg_type == p2_tx_type);
  wire p2_rx_qual = p2_rx_frame && p2_is_ptp && (p2_msg_type == p2_rx_type);
  // a held flag blocks only while the lock is on
  wire rx_store = p2_rx_qual && !(p2_lock_rx && rx_flag_ff);
  wire tx_store = p2_tx_qual && !(p2_lock_tx && tx_flag_ff);

  wire [3:0] p1_tx_type = p1_master ? MSG_SYNC : MSG_DELAY_REQ;
  wire [3:0] p1_rx_type = p1_master ? MSG_DELAY_REQ : MSG_SYNC;
  wire p1_tx_qual = p1_tx_frame && (p1_msg_type == p1_tx_type);
  wire p1_rx_qual = p1_rx_frame && (p1_msg_type == p1_rx_type);

  // set beats clear when both land in one cycle
  wire nxt_rx_flag = rx_store || (rx_flag_ff && !clr_rx);
  wire nxt_tx_flag = tx_store || (tx_flag_ff && !clr_tx);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_cfg = {cfg_ff, {CFG_LSB{1'b0}}};
  wire [31:0] rd_upper = {{(32-AUX_UPPER_W){1'b0}}, aux_upper_ff};
  wire [31:0] rd_stat = {30'h0, tx_flag_ff, rx_flag_ff};
  wire [31:0] nxt_prdata = hit_cfg ? rd_cfg :
                           hit_upper ? rd_upper :
                           hit_lower ? aux_lower_ff :
                           hit_stat ? rd_stat : 32'h0;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= CFG_RESET;
      aux_upper_ff <= '0;
      aux_lower_ff <= '0;
      prdata <= '0;
    end else if (clk_en) begin
      if (wr_cfg) cfg_ff <= pwdata[31:CFG_LSB];
      if (wr_upper) aux_upper_ff <= upper_wdata;
      if (wr_lower) aux_lower_ff <= pwdata;
      if (psel && !penable && !pwrite) prdata <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------
  // capture storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_clock_ff <= '0;
      rx_uid_ff <= '0;
      rx_seq_ff <= '0;
      rx_flag_ff <= 1'b0;
    end else if (clk_en) begin
      rx_flag_ff <= nxt_rx_flag;
      if (rx_store) begin
        rx_clock_ff <= clock_now;
        rx_uid_ff <= p2_src_uid;
        rx_seq_ff <= p2_seq_id;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_clock_ff <= '0;
      tx_uid_ff <= '0;
      tx_seq_ff <= '0;
      tx_flag_ff <= 1'b0;
    end else if (clk_en) begin
      tx_flag_ff <= nxt_tx_flag;
      if (tx_store) begin
        tx_clock_ff <= clock_now;
        tx_uid_ff <= p2_src_uid;
        tx_seq_ff <= p2_seq_id;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_tx_cap_ff <= 1'b0;
      p1_rx_cap_ff <= 1'b0;
    end else if (clk_en) begin
      p1_tx_cap_ff <= p1_tx_qual;
      p1_rx_cap_ff <= p1_rx_qual;
    end
  end

  assign p2_rx_clock = rx_clock_ff;
  assign p2_rx_uid = rx_uid_ff;
  assign p2_rx_seq = rx_seq_ff;
  assign p2_tx_clock = tx_clock_ff;
  assign p2_tx_uid = tx_uid_ff;
  assign p2_tx_seq = tx_seq_ff;
  assign p2_rx_flag = rx_flag_ff;
  assign p2_tx_flag = tx_flag_ff;
  assign p1_tx_capture = p1_tx_cap_ff;
  assign p1_rx_capture = p1_rx_cap_ff;
  assign p1_master_role = p1_master;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_master_tx_sync: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && p2_master && p2_tx_frame && p2_is_ptp && p2_msg_type == MSG_SYNC
     && !(p2_lock_tx && tx_flag_ff)) |=> (tx_flag_ff && tx_clock_ff == $past(clock_now)))
    else $error("master sent sync not captured");

  a_slave_rx_sync: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !p2_master && p2_rx_frame && p2_is_ptp && p2_msg_type == MSG_SYNC
     && !(p2_lock_rx && rx_flag_ff)) |=> (rx_flag_ff && rx_seq_ff == $past(p2_seq_id)))
    else $error("slave received sync not captured");

  a_slave_no_tx_sync: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !p2_master && p2_msg_type == MSG_SYNC) |-> !tx_store)
    else $error("slave captured sent sync");

  a_primary_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (p2_dest_addr == PTP_PRI_ADDR && !m_user) |-> (p2_is_ptp == p2_pri_en))
    else $error("primary address recognition wrong");

  a_alt1_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (p2_alt1_en && p2_dest_addr == PTP_ALT1_ADDR) |-> p2_is_ptp)
    else $error("alternate 1 address missed");

  a_alt3_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (p2_alt3_en && p2_dest_addr == PTP_ALT3_ADDR) |-> p2_is_ptp)
    else $error("alternate 3 address missed");

  a_user_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (p2_user_en && p2_dest_addr == {aux_upper_ff, aux_lower_ff}) |-> p2_is_ptp)
    else $error("user address missed");

  a_rx_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && p2_lock_rx && rx_flag_ff) |=> $stable(rx_clock_ff) && $stable(rx_uid_ff))
    else $error("locked rx capture overwritten");

  a_tx_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && p2_lock_tx && tx_flag_ff) |=> $stable(tx_clock_ff) && $stable(tx_seq_ff))
    else $error("locked tx capture overwritten");

  a_p1_role: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && p1_tx_frame && p1_msg_type == MSG_SYNC) |=> (p1_tx_capture == $past(p1_master)))
    else $error("port 1 tx capture role wrong");

  a_unlocked_write: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !p2_lock_rx && p2_rx_qual) |=> (rx_uid_ff == $past(p2_src_uid)))
    else $error("unlocked rx capture dropped");

  a_alt2_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (p2_alt2_en && p2_dest_addr == PTP_ALT2_ADDR) |-> p2_is_ptp)
    else $error("alternate 2 address missed");

  a_alt1_off: assert property (@(posedge clk) disable iff (!rst_n)
    (!p2_alt1_en && !m_user && p2_dest_addr == PTP_ALT1_ADDR) |-> !p2_is_ptp)
    else $error("disabled alternate 1 address accepted");

  a_user_off: assert property (@(posedge clk) disable iff (!rst_n)
    (!p2_user_en && p2_dest_addr == aux_addr
     && !m_pri && !m_alt1 && !m_alt2 && !m_alt3) |-> !p2_is_ptp)
    else $error("disabled user address accepted");

  a_master_rx_dreq: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && p2_master && p2_rx_frame && p2_is_ptp && p2_msg_type == MSG_DELAY_REQ
     && !(p2_lock_rx && rx_flag_ff)) |=> (rx_flag_ff && rx_clock_ff == $past(clock_now)))
    else $error("master received delay request not captured");

  a_slave_tx_dreq: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !p2_master && p2_tx_frame && p2_is_ptp && p2_msg_type == MSG_DELAY_REQ
     && !(p2_lock_tx && tx_flag_ff)) |=> (tx_flag_ff && tx_uid_ff == $past(p2_src_uid)))
    else $error("slave sent delay request not captured");

  a_master_no_rx_sync: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && p2_master && p2_msg_type == MSG_SYNC) |-> !rx_store)
    else $error("master captured received sync");

  a_non_ptp_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    !p2_is_ptp |-> !(rx_store || tx_store))
    else $error("frame without enabled address captured");

  a_p1_rx_role: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && p1_rx_frame && p1_msg_type == MSG_SYNC) |=> (p1_rx_capture != $past(p1_master)))
    else $error("port 1 rx capture role wrong");

  a_p1_tx_dreq: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && p1_tx_frame && p1_msg_type == MSG_DELAY_REQ)
    |=> (p1_tx_capture != $past(p1_master)))
    else $error("port 1 tx delay request role wrong");

  a_unlocked_tx: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !p2_lock_tx && p2_tx_qual) |=> (tx_seq_ff == $past(p2_seq_id)))
    else $error("unlocked tx capture dropped");

  // ----------------------------------------------------------------
  // checks: flags, bus and clock enable
  // ----------------------------------------------------------------
  // the flag clears only when no capture lands in the same cycle
  a_rx_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && clr_rx && !rx_store) |=> !rx_flag_ff)
    else $error("rx flag not cleared");

  a_tx_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && clr_tx && !tx_store) |=> !tx_flag_ff)
    else $error("tx flag not cleared");

  a_aux_upper_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_upper |=> (aux_upper_ff == $past(upper_wdata)))
    else $error("auxiliary upper write lost");

  a_aux_lower_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_lower |=> (aux_lower_ff == $past(pwdata)))
    else $error("auxiliary lower write lost");

  // a frozen block keeps every setting and flag for that cycle
  a_frozen_state: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en |=> ($stable(cfg_ff) && $stable(rx_flag_ff) && $stable(tx_flag_ff)))
    else $error("state changed while clock enable low");

endmodule : ptc_capture_cfg

// file: dv/ptc_frame_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// frame source for the port 1 and port 2 timestamp points
// ----------------------------------------------------------------
module ptc_frame_model (
  input wire logic clk,
  output logic p2_tx_frame,
  output logic p2_rx_frame,
  output logic [47:0] p2_dest_addr,
  output logic [3:0] p2_msg_type,
  output logic [47:0] p2_src_uid,
  output logic [15:0] p2_seq_id,
  output logic [63:0] clock_now,
  output logic p1_tx_frame,
  output logic p1_rx_frame,
  output logic [3:0] p1_msg_type
);
  initial begin
    {p2_tx_frame, p2_rx_frame, p1_tx_frame, p1_rx_frame} = 4'h0;
    {p2_dest_addr, p2_msg_type, p2_src_uid, p2_seq_id, clock_now, p1_msg_type} = '0;
  end

  // fields are inverted once the strobe drops, so stale values never pass
  task automatic send(input logic p1, input logic tx, input logic [47:0] da,
      input logic [3:0] mt, input logic [15:0] sq);
    {p1_tx_frame, p1_rx_frame} <= {p1 & tx, p1 & !tx};
    {p2_tx_frame, p2_rx_frame} <= {!p1 & tx, !p1 & !tx};
    p2_dest_addr <= da;
    p2_msg_type <= mt;
    p1_msg_type <= mt;
    p2_src_uid <= {3{sq}};
    p2_seq_id <= sq;
    clock_now <= {4{sq}};
    @(posedge clk);
    {p2_tx_frame, p2_rx_frame, p1_tx_frame, p1_rx_frame} <= 4'h0;
    p2_dest_addr <= ~da;
    p2_msg_type <= ~mt;
    p1_msg_type <= ~mt;
    p2_src_uid <= ~{3{sq}};
    p2_seq_id <= ~sq;
    clock_now <= ~{4{sq}};
    @(posedge clk);
  endtask : send
endmodule : ptc_frame_model

// file: dv/test_ptp_timestamp_capture_config.sv
`timescale 1ns/1ns
module test_ptp_timestamp_capture_config
  import ptc_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic p2_tx_frame, p2_rx_frame, p1_tx_frame, p1_rx_frame, p2_rx_flag, p2_tx_flag;
  logic [47:0] p2_dest_addr, p2_src_uid, p2_rx_uid, p2_tx_uid;
  logic [3:0] p2_msg_type, p1_msg_type;
  logic [15:0] p2_seq_id, p2_rx_seq, p2_tx_seq;
  logic [15:0] seq_n = 16'h0100;
  logic [63:0] clock_now, p2_rx_clock, p2_tx_clock;
  logic p1_tx_capture, p1_rx_capture, p1_master_role;
  int err_total = 0, n_tests = 0, n_p1tx = 0, n_p1rx = 0;

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (p1_tx_capture === 1'b1) n_p1tx <= n_p1tx + 1;
    if (p1_rx_capture === 1'b1) n_p1rx <= n_p1rx + 1;
  end

  ptc_capture_cfg dut (.clk, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .p2_tx_frame, .p2_rx_frame, .p2_dest_addr, .p2_msg_type,
    .p2_src_uid, .p2_seq_id, .clock_now, .p1_tx_frame, .p1_rx_frame, .p1_msg_type,
    .p2_rx_clock, .p2_rx_uid, .p2_rx_seq, .p2_tx_clock, .p2_tx_uid, .p2_tx_seq, .p2_rx_flag,
    .p2_tx_flag, .p1_tx_capture, .p1_rx_capture, .p1_master_role);
  ptc_frame_model fm (.clk, .p2_tx_frame, .p2_rx_frame, .p2_dest_addr, .p2_msg_type,
    .p2_src_uid, .p2_seq_id, .clock_now, .p1_tx_frame, .p1_rx_frame, .p1_msg_type);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask : apb

  task automatic cfg(input logic [8:0] f);
    apb(1'b1, CAPTURE_CFG_ADDR, {f, 23'h0});
  endtask : cfg

  task automatic frame(input logic p1, input logic tx, input logic [47:0] da,
      input logic [3:0] mt, input logic clr, input logic e);
    int c0;
    logic got;
    if (clr) apb(1'b1, PORT2_STATUS_ADDR, 32'h3);
    c0 = tx ? n_p1tx : n_p1rx;
    seq_n++;
    fm.send(p1, tx, da, mt, seq_n);
    @(posedge clk);
    got = p1 ? ((tx ? n_p1tx : n_p1rx) - c0 == 1) : (tx ? p2_tx_flag : p2_rx_flag);
    chk("capture", {63'h0, e}, {63'h0, got});
    if (!p1 && e && clr) begin
      chk("seq", {48'h0, seq_n}, {48'h0, tx ? p2_tx_seq : p2_rx_seq});
      chk("clock", {4{seq_n}}, tx ? p2_tx_clock : p2_rx_clock);
      chk("uid", {16'h0, {3{seq_n}}}, {16'h0, tx ? p2_tx_uid : p2_rx_uid});
    end
  endtask : frame

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, CAPTURE_CFG_ADDR, 32'h0);
    chk("cfg reset", 64'h43000000, {32'h0, rd});
    chk("port1 role", 64'h0, {63'h0, p1_master_role});
    apb(1'b0, 12'h1A0, 32'h0);
    chk("unmapped err", 64'h1, {63'h0, er});
    frame(1'b0, 1'b0, PTP_ALT1_ADDR, MSG_SYNC, 1'b1, 1'b0);
    frame(1'b0, 1'b0, PTP_PRI_ADDR, MSG_SYNC, 1'b1, 1'b1);
    cfg(9'h1FF);
    apb(1'b0, CAPTURE_CFG_ADDR, 32'h0);
    chk("cfg rw", 64'hFF800000, {32'h0, rd});
  endtask : t_reset

  task automatic t_roles;
    logic e;
    logic [3:0] mt;
    for (int r = 0; r < 2; r++) begin
      cfg(r ? 9'h187 : 9'h086);
      chk("port1 role", r, {63'h0, p1_master_role});
      for (int d = 0; d < 2; d++)
        for (int m = 0; m < 2; m++) begin
          e = (r == d) ? (m == 0) : (m == 1);
          mt = m ? MSG_DELAY_REQ : MSG_SYNC;
          frame(1'b0, d[0], PTP_PRI_ADDR, mt, 1'b1, e);
          frame(1'b1, d[0], PTP_PRI_ADDR, mt, 1'b1, e);
        end
    end
  endtask : t_roles

  task automatic t_addr;
    logic [47:0] da [5];
    da = '{PTP_PRI_ADDR, PTP_ALT1_ADDR, PTP_ALT2_ADDR, PTP_ALT3_ADDR, 48'hABCD12345678};
    apb(1'b1, AUX_UPPER_ADDR, 32'h0000ABCD);
    apb(1'b1, AUX_LOWER_ADDR, 32'h12345678);
    apb(1'b0, AUX_UPPER_ADDR, 32'h0);
    chk("aux upper", 64'hABCD, {32'h0, rd});
    apb(1'b0, AUX_LOWER_ADDR, 32'h0);
    chk("aux lower", 64'h12345678, {32'h0, rd});
    // slot 5 enables every address at once, slot 6 none of them
    for (int en = 0; en < 7; en++) begin
      cfg(en == 5 ? 9'h0FE : (en == 6 ? 9'h006 : (9'h006 | (9'h080 >> en))));
      for (int a = 0; a < 5; a++)
        frame(1'b0, 1'b0, da[a], MSG_SYNC, 1'b1, en == 5 || en == a);
    end
  endtask : t_addr

  task automatic t_locks;
    logic [15:0] s0;
    for (int d = 0; d < 2; d++)
      for (int lk = 0; lk < 2; lk++) begin
        // only the other direction's lock is set when lk is clear
        cfg(9'h080 | ((lk == d) ? 9'h002 : 9'h004));
        frame(1'b0, d[0], PTP_PRI_ADDR, d ? MSG_DELAY_REQ : MSG_SYNC, 1'b1, 1'b1);
        s0 = seq_n;
        frame(1'b0, d[0], PTP_PRI_ADDR, d ? MSG_DELAY_REQ : MSG_SYNC, 1'b0, 1'b1);
        chk("held seq", {48'h0, lk ? s0 : seq_n}, {48'h0, d ? p2_tx_seq : p2_rx_seq});
        apb(1'b0, PORT2_STATUS_ADDR, 32'h0);
        chk("status", d ? 64'h2 : 64'h1, {32'h0, rd});
      end
  endtask : t_locks

  // a frame offered while the clock enable is low must leave no trace
  task automatic t_freeze;
    apb(1'b1, PORT2_STATUS_ADDR, 32'h3);
    clk_en <= 1'b0;
    @(posedge clk);
    chk("pready frozen", 64'h0, {63'h0, pready});
    fm.send(1'b0, 1'b0, PTP_PRI_ADDR, MSG_SYNC, 16'h0F0F);
    clk_en <= 1'b1;
    @(posedge clk);
    chk("frozen capture", 64'h0, {63'h0, p2_rx_flag});
  endtask : t_freeze

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_roles;
    t_addr;
    t_locks;
    t_freeze;
    summarize;
  end

  // run needs about 450 cycles; 40000 leaves a wide margin
  initial begin
    #2000000;
    err_total++;
    summarize;
  end
endmodule : test_ptp_timestamp_capture_config
